// file: rtl/pm_defines.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH

`define PM_IDX_IDLE      8'h40
`define PM_IDX_WAKE      8'h41
`define PM_IDX_LEVEL     8'h42
`define PM_IDX_RSVD_A    8'h43
`define PM_IDX_RSVD_B    8'h44
`define PM_IDX_ENABLE    8'h45

`define PM_BIT_PRT       3
`define PM_BIT_FDC       2
`define PM_BIT_URA       1
`define PM_BIT_URB       0

`define PM_FLAGS_RST     4'h0
`define PM_INDEX_RST     8'h00
`define PM_TIMER_RST     8'h00
`define PM_RSVD_READ     4'h0

`define PM_CLK_HZ        50000000
`define PM_TICK_S        1
`define PM_SEC_CYCLES    (`PM_CLK_HZ * `PM_TICK_S)
`define PM_MIN_SECS      60

`endif

// file: rtl/pm_pkg.sv
// Types shared by the power-management status block.
package pm_pkg;

  // Power-down machine states, Gray coded.
  typedef enum logic [0:0] {
    PD_WORK  = 1'b0,
    PD_SLEEP = 1'b1
  } pd_state_e;

  // State of one power-down machine.
  typedef struct packed {
    pd_state_e  state;
    logic [7:0] timer;
  } pd_s;

  // One cycle of the host configuration port.
  typedef struct packed {
    logic       ext_mode;
    logic       idx_wr;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] wdata;
  } host_req_s;

  // Activity seen by the power-down logic of one UART.
  typedef struct packed {
    logic       rx_start;
    logic       tx_start;
    logic       rx_wait_start;
    logic       tx_empty;
    logic [3:0] modem;
  } uart_act_s;

  // State of the status block outside its power-down machines.
  typedef struct packed {
    logic [7:0]  index;
    logic [3:0]  idle;
    logic [3:0]  wake;
    logic [3:0]  int_en;
    logic [7:0]  rdata;
    logic [4:0]  prt_prev;
    logic [3:0]  motor_prev;
    logic [3:0]  modem_a_prev;
    logic [3:0]  modem_b_prev;
    logic [25:0] sec_cnt;
    logic [5:0]  min_cnt;
    logic        mgmt_int;
    logic        serial_int;
  } blk_s;

endpackage

// file: rtl/pd_machine.sv
// Power-down machine of one peripheral: idle timer and work/sleep state.
`timescale 1ns/1ps
`default_nettype none
`include "pm_defines.svh"

module pd_machine (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       wake,
  input  wire logic       quiet,
  input  wire logic [7:0] init_count,
  output logic            to_sleep,
  output logic            to_work
);
  import pm_pkg::*;

  pd_s cur;       // Registered state.
  pd_s next_cur;  // Next state.

  // ------------------------------------------------------------------
  // Next-state logic.
  // ------------------------------------------------------------------
  // The machine freezes while power management is off, so a device keeps
  // whatever state it had when software turned the feature off.
  always_comb begin
    next_cur = cur;
    to_sleep = 1'b0;
    to_work  = 1'b0;
    if (run) begin
      if (wake) begin
        next_cur.timer = init_count;
        unique case (cur.state)
          PD_SLEEP: begin
            next_cur.state = PD_WORK;
            to_work        = 1'b1;
          end
          PD_WORK: begin
            next_cur.state = PD_WORK;
          end
        endcase
      end else if (cur.state == PD_WORK && init_count != `PM_TIMER_RST && quiet && tick) begin
        // A zero count never expires, so power-down is off for it.
        if (cur.timer == `PM_TIMER_RST) begin
          next_cur.timer = init_count;
        end else if (cur.timer == 8'h01) begin
          next_cur.timer = `PM_TIMER_RST;
          next_cur.state = PD_SLEEP;
          to_sleep       = 1'b1;
        end else begin
          next_cur.timer = cur.timer - 8'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // State register.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{state: PD_WORK, timer: `PM_TIMER_RST};
    end else begin
      cur <= next_cur;
    end
  end

  chk_zero_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (init_count == `PM_TIMER_RST && !wake) |=> cur.state == $past(cur.state))
    else $error("Power-down machine slept with a zero count.");

endmodule
`default_nettype wire

// file: rtl/pm_idle_trap_smi_status.sv
// Idle, wake and interrupt-level status with management interrupt steering.
//
// What this block does
// - Idle timer expiry sets device idle bit.
// - Writing one clears status bit; zero ignored.
// - Upper four bits always read zero.
// - Printer idle: no access, irq, ack, pin edge.
// - Floppy idle: no access, irq, ack, motors.
// - UART idle: quiet, receiver waiting, transmitter empty.
// - Wake sets trap bit, reloads idle timer.
// - Printer wakes on access, irq, ack, pins.
// - Floppy wakes on access, irq, ack, motor.
// - UART wakes on access, irq, start, modem.
// - Level register mirrors interrupt pins, read-only.
// - Edge printer interrupt may read low.
// - Request is OR of enabled interrupt levels.
// - Output needs request, pin and chip enable.
// - Enable bits gate printer, floppy, UART A, B.
// - Indexes 43h and 44h read zero.
// - Timer counts down; zero count disables.
// - Pin enable drives pin and serial line.
// - Timers run only with chip enable set.
`timescale 1ns/1ps
`default_nettype none
`include "pm_defines.svh"

module pm_idle_trap_smi_status #(
  parameter int SEC_CYCLES = `PM_SEC_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire pm_pkg::host_req_s host,
  output logic [7:0]             host_rdata,
  input  wire logic [3:0]        dev_access,
  input  wire logic [3:0]        dev_irq,
  input  wire logic              prt_dack,
  input  wire logic [4:0]        prt_status,
  input  wire logic              fdc_dack,
  input  wire logic [3:0]        fdc_motor,
  input  wire pm_pkg::uart_act_s uart_a,
  input  wire pm_pkg::uart_act_s uart_b,
  input  wire logic [3:0][7:0]   idle_count,
  input  wire logic              chip_power_mgmt_enable,
  input  wire logic [3:0]        dev_pm_enable,
  input  wire logic              tmin_sel,
  input  wire logic              mgmt_int_pin_enable,
  input  wire logic              serial_irq_mode,
  output logic                   mgmt_int_n,
  output logic                   mgmt_int_serial
);
  import pm_pkg::*;

  // ------------------------------------------------------------------
  // Declarations.
  // ------------------------------------------------------------------
  blk_s       cur;        // Registered state of the block.
  blk_s       next_cur;   // Next state.
  logic       wr_data;    // Data-port write in extended function mode.
  logic       rd_data;    // Data-port read in extended function mode.
  logic       wr_idle;    // Write aimed at the idle status register.
  logic       wr_wake;    // Write aimed at the wake status register.
  logic       wr_en;      // Write aimed at the enable register.
  logic [3:0] wake_evt;   // Per-device wake cause this cycle.
  logic [3:0] quiet;      // Per-device quiet condition this cycle.
  logic [3:0] sleep_go;   // Per-device work-to-sleep transition.
  logic [3:0] work_go;    // Per-device sleep-to-work transition.
  logic       sec_tick;   // One-second enable pulse.
  logic       tick;       // Selected idle timer resolution pulse.
  logic       mgmt_req;   // Combined management request.

  // ------------------------------------------------------------------
  // Host port decode.
  // ------------------------------------------------------------------
  // Nothing is reachable outside extended function mode, so stray data
  // cycles from normal operation never disturb the flags.
  assign wr_data = host.ext_mode && host.data_wr;
  assign rd_data = host.ext_mode && host.data_rd;
  assign wr_idle = wr_data && cur.index == `PM_IDX_IDLE;
  assign wr_wake = wr_data && cur.index == `PM_IDX_WAKE;
  assign wr_en   = wr_data && cur.index == `PM_IDX_ENABLE;

  // ------------------------------------------------------------------
  // Wake causes per device.
  // ------------------------------------------------------------------
  // Edges on status pins are found against last cycle's sample; the
  // inputs are already synchronous to this clock.
  assign wake_evt[`PM_BIT_PRT] = dev_access[`PM_BIT_PRT] || dev_irq[`PM_BIT_PRT]
    || prt_dack || |(prt_status ^ cur.prt_prev);
  assign wake_evt[`PM_BIT_FDC] = dev_access[`PM_BIT_FDC] || dev_irq[`PM_BIT_FDC]
    || fdc_dack || |(fdc_motor & ~cur.motor_prev);
  assign wake_evt[`PM_BIT_URA] = dev_access[`PM_BIT_URA] || dev_irq[`PM_BIT_URA]
    || uart_a.rx_start || uart_a.tx_start || |(uart_a.modem ^ cur.modem_a_prev);
  assign wake_evt[`PM_BIT_URB] = dev_access[`PM_BIT_URB] || dev_irq[`PM_BIT_URB]
    || uart_b.rx_start || uart_b.tx_start || |(uart_b.modem ^ cur.modem_b_prev);

  // ------------------------------------------------------------------
  // Quiet conditions per device.
  // ------------------------------------------------------------------
  // A running motor keeps the floppy awake even without bus traffic.
  assign quiet[`PM_BIT_PRT] = !wake_evt[`PM_BIT_PRT];
  assign quiet[`PM_BIT_FDC] = !wake_evt[`PM_BIT_FDC] && fdc_motor == 4'h0;
  assign quiet[`PM_BIT_URA] = !wake_evt[`PM_BIT_URA] && uart_a.rx_wait_start
    && uart_a.tx_empty;
  assign quiet[`PM_BIT_URB] = !wake_evt[`PM_BIT_URB] && uart_b.rx_wait_start
    && uart_b.tx_empty;

  // ------------------------------------------------------------------
  // Timer resolution.
  // ------------------------------------------------------------------
  // The minute pulse is every sixtieth second pulse, so both share one
  // divider and no second long counter is needed.
  assign sec_tick = cur.sec_cnt == 26'(SEC_CYCLES - 1);
  assign tick     = tmin_sel ? (sec_tick && cur.min_cnt == 6'(`PM_MIN_SECS - 1)) : sec_tick;

  // ------------------------------------------------------------------
  // Power-down machines, one per device.
  // ------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_pd
    pd_machine u_pd (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .run        (chip_power_mgmt_enable && dev_pm_enable[g]),
      .tick       (tick),
      .wake       (wake_evt[g]),
      .quiet      (quiet[g]),
      .init_count (idle_count[g]),
      .to_sleep   (sleep_go[g]),
      .to_work    (work_go[g])
    );
  end

  // ------------------------------------------------------------------
  // Management request.
  // ------------------------------------------------------------------
  // The printer line may be a short edge pulse; it still reaches the
  // request, though software reading the level may see it low.
  assign mgmt_req = |(cur.int_en & dev_irq);

  // ------------------------------------------------------------------
  // Next-state logic.
  // ------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    // Index port: the host picks a register before touching data.
    if (host.ext_mode && host.idx_wr) begin
      next_cur.index = host.wdata;
    end
    // Status flags: hardware set wins over a software clear in the same
    // cycle, so no transition is ever lost.
    next_cur.idle = (cur.idle & ~(wr_idle ? host.wdata[3:0] : 4'h0) & ~work_go)
      | sleep_go;
    next_cur.wake = (cur.wake & ~(wr_wake ? host.wdata[3:0] : 4'h0) & ~sleep_go)
      | work_go;
    if (wr_en) begin
      next_cur.int_en = host.wdata[3:0];
    end
    // Read data is captured on the read strobe and held until the next.
    if (rd_data) begin
      unique case (cur.index)
        `PM_IDX_IDLE:   next_cur.rdata = {`PM_RSVD_READ, cur.idle};
        `PM_IDX_WAKE:   next_cur.rdata = {`PM_RSVD_READ, cur.wake};
        `PM_IDX_LEVEL:  next_cur.rdata = {`PM_RSVD_READ, dev_irq};
        `PM_IDX_ENABLE: next_cur.rdata = {`PM_RSVD_READ, cur.int_en};
        default:        next_cur.rdata = 8'h00;
      endcase
    end
    // Edge history for the wake detectors.
    next_cur.prt_prev     = prt_status;
    next_cur.motor_prev   = fdc_motor;
    next_cur.modem_a_prev = uart_a.modem;
    next_cur.modem_b_prev = uart_b.modem;
    // Second divider and minute counter.
    if (sec_tick) begin
      next_cur.sec_cnt = 26'h0;
      next_cur.min_cnt = (cur.min_cnt == 6'(`PM_MIN_SECS - 1)) ? 6'h0 : cur.min_cnt + 6'h1;
    end else begin
      next_cur.sec_cnt = cur.sec_cnt + 26'h1;
    end
    // Output steering: both enables must be set to drive the pin.
    next_cur.mgmt_int   = mgmt_req && mgmt_int_pin_enable && chip_power_mgmt_enable;
    next_cur.serial_int = next_cur.mgmt_int && serial_irq_mode;
  end

  // ------------------------------------------------------------------
  // State register.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{index: `PM_INDEX_RST, idle: `PM_FLAGS_RST, wake: `PM_FLAGS_RST,
               int_en: `PM_FLAGS_RST, rdata: 8'h00, prt_prev: 5'h0, motor_prev: 4'h0,
               modem_a_prev: 4'h0, modem_b_prev: 4'h0, sec_cnt: 26'h0, min_cnt: 6'h0,
               mgmt_int: 1'b0, serial_int: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------------
  // Outputs.
  // ------------------------------------------------------------------
  assign host_rdata      = cur.rdata;
  assign mgmt_int_n      = !cur.mgmt_int;
  assign mgmt_int_serial = cur.serial_int;

  // ------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Ones written to the idle flags clear them.
  chk_w1c_clear: assert property (wr_idle && host.wdata[3:0] == 4'hF && sleep_go == 4'h0
    |=> cur.idle == 4'h0)
    else $error("Idle flags not cleared by writing ones.");

  // Zeros written to the wake flags leave them alone.
  chk_w0_keeps: assert property (wr_wake && host.wdata[3:0] == 4'h0
    && sleep_go == 4'h0 && work_go == 4'h0 |=> cur.wake == $past(cur.wake))
    else $error("Writing zero changed the wake flags.");

  // Zeros written to the idle flags leave them alone.
  chk_idle_w0_keeps: assert property (wr_idle && host.wdata[3:0] == 4'h0
    && sleep_go == 4'h0 && work_go == 4'h0 |=> cur.idle == $past(cur.idle))
    else $error("Writing zero changed the idle flags.");

  // A sleep transition raises its idle flag.
  chk_sleep_sets: assert property (sleep_go != 4'h0
    |=> (cur.idle & $past(sleep_go)) == $past(sleep_go))
    else $error("Sleep transition did not set its idle flag.");

  // A wake transition raises its trap flag.
  chk_wake_sets: assert property (work_go != 4'h0
    |=> (cur.wake & $past(work_go)) == $past(work_go))
    else $error("Wake transition did not set its trap flag.");

  // No device shows idle and woken at once after a transition.
  chk_flags_apart: assert property ((sleep_go | work_go) != 4'h0
    |=> (cur.idle & cur.wake & $past(sleep_go | work_go)) == 4'h0)
    else $error("Idle and trap flags both set after a transition.");

  // Reserved indexes read zero.
  chk_rsvd_zero: assert property (rd_data && (cur.index == `PM_IDX_RSVD_A
    || cur.index == `PM_IDX_RSVD_B) |=> host_rdata == 8'h00)
    else $error("Reserved register read non-zero.");

  // The upper nibble of every register reads zero.
  chk_upper_zero: assert property (rd_data |=> host_rdata[7:4] == 4'h0)
    else $error("Reserved upper bits read non-zero.");

  // The level register shows the pins of the read cycle.
  chk_level_mirror: assert property (rd_data && cur.index == `PM_IDX_LEVEL
    |=> host_rdata[3:0] == $past(dev_irq))
    else $error("Level register does not follow the interrupt pins.");

  // An enable write reads back while the index stays on the enable register.
  chk_en_readback: assert property (wr_en ##1 !wr_en
    ##1 (rd_data && cur.index == `PM_IDX_ENABLE)
    |=> host_rdata == {4'h0, $past(host.wdata[3:0], 3)})
    else $error("Enable register did not read back its write.");

  // Either enable off releases the pin.
  chk_gate_out: assert property (!mgmt_int_pin_enable || !chip_power_mgmt_enable
    |=> mgmt_int_n)
    else $error("Management interrupt driven while disabled.");

  // An enabled level with both enables set drives the pin a cycle later.
  chk_req_drives: assert property ((cur.int_en & dev_irq) != 4'h0
    && mgmt_int_pin_enable && chip_power_mgmt_enable |=> !mgmt_int_n)
    else $error("Enabled request did not drive the management pin.");

  // Without an enabled level the pin stays released.
  chk_mask_holds: assert property ((cur.int_en & dev_irq) == 4'h0 |=> mgmt_int_n)
    else $error("Management pin driven without an enabled request.");

  // The serial copy follows the pin in serial IRQ mode.
  chk_serial_route: assert property (!mgmt_int_n && serial_irq_mode
    |-> ##0 $past(serial_irq_mode) ? mgmt_int_serial : 1'b1)
    else $error("Serial line missed the management interrupt.");

  // The serial copy stays low outside serial IRQ mode.
  chk_serial_off: assert property (!serial_irq_mode |=> !mgmt_int_serial)
    else $error("Serial line driven outside serial IRQ mode.");

  // Outside extended function mode the host moves neither index nor enables.
  chk_mode_gate: assert property (!host.ext_mode
    |=> cur.index == $past(cur.index) && cur.int_en == $past(cur.int_en))
    else $error("Host port changed state outside extended function mode.");

  // ------------------------------------------------------------------
  // Cover points.
  // ------------------------------------------------------------------
  cov_sleep:  cover property (sleep_go != 4'h0);
  cov_wake:   cover property (work_go != 4'h0);
  cov_int:    cover property (!mgmt_int_n ##1 mgmt_int_n);
  cov_w1c:    cover property (wr_idle && host.wdata[3:0] != 4'h0);
  cov_minute: cover property (tmin_sel && tick);

endmodule
`default_nettype wire

// file: verification/host_port_model.sv
// Host-side model that drives the indexed configuration port.
`timescale 1ns/1ps
`default_nettype none

module host_port_model (
  input  wire logic             sys_clk,
  output var pm_pkg::host_req_s host
);
  import pm_pkg::*;

  // The port starts idle, with extended function mode already entered.
  initial begin
    host = '0;
    host.ext_mode = 1'b1;
  end

  // Extended function mode is a level that the host keeps between cycles.
  task automatic set_ext(input logic on);
    @(negedge sys_clk);
    host.ext_mode = on;
  endtask

  // One strobe held for one rising edge: 0 index, 1 data write, 2 data read.
  task automatic strobe(input int kind, input logic [7:0] val);
    @(negedge sys_clk);
    host.idx_wr  = (kind == 0);
    host.data_wr = (kind == 1);
    host.data_rd = (kind == 2);
    host.wdata   = val;
    @(negedge sys_clk);
    host.idx_wr  = 1'b0;
    host.data_wr = 1'b0;
    host.data_rd = 1'b0;
    // Released data shows the inverse, so a stale byte is never mistaken for valid.
    host.wdata   = ~val;
  endtask
endmodule
`default_nettype wire

// file: verification/pm_idle_trap_smi_status_tb.sv
// Self-checking bench for the power-management status block.
`timescale 1ns/1ps
`default_nettype none
`include "pm_defines.svh"

module pm_idle_trap_smi_status_tb;
  import pm_pkg::*;

  localparam int SEC = 4; // A short second keeps the idle timers quick.

  logic            sys_clk = 1'b0;
  logic            rst_n;
  host_req_s       host;
  logic [7:0]      host_rdata;
  logic [3:0]      dev_access;
  logic [3:0]      dev_irq;
  logic            prt_dack;
  logic [4:0]      prt_status;
  logic            fdc_dack;
  logic [3:0]      fdc_motor;
  uart_act_s       uart_a;
  uart_act_s       uart_b;
  logic [3:0][7:0] idle_count;
  logic            chip_power_mgmt_enable;
  logic [3:0]      dev_pm_enable;
  logic            tmin_sel;
  logic            mgmt_int_pin_enable;
  logic            serial_irq_mode;
  logic            mgmt_int_n;
  logic            mgmt_int_serial;
  logic            rd_pend = 1'b0;
  logic [31:0]     seed;
  logic [31:0]     r;
  logic            hit;
  logic [7:0]      exp_q[$];
  int              miscompares = 0;
  int              comparisons = 0;

  pm_idle_trap_smi_status #(.SEC_CYCLES(SEC)) u_pm_idle_trap_smi_status (
    .sys_clk(sys_clk), .rst_n(rst_n), .host(host), .host_rdata(host_rdata),
    .dev_access(dev_access), .dev_irq(dev_irq), .prt_dack(prt_dack),
    .prt_status(prt_status), .fdc_dack(fdc_dack), .fdc_motor(fdc_motor),
    .uart_a(uart_a), .uart_b(uart_b), .idle_count(idle_count),
    .chip_power_mgmt_enable(chip_power_mgmt_enable), .dev_pm_enable(dev_pm_enable),
    .tmin_sel(tmin_sel), .mgmt_int_pin_enable(mgmt_int_pin_enable),
    .serial_irq_mode(serial_irq_mode), .mgmt_int_n(mgmt_int_n),
    .mgmt_int_serial(mgmt_int_serial)
  );

  host_port_model u_host_port_model (.sys_clk(sys_clk), .host(host));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Next value of the xorshift generator; the sequence is fixed by its start.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Compares one read byte with its note.
  task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR host_rdata expected %h seen %h", exp, got);
    end
  endtask

  // Compares both management interrupt outputs at once.
  task automatic cmp_pins(input logic exp_n, input logic exp_s);
    comparisons++;
    if ({mgmt_int_n, mgmt_int_serial} !== {exp_n, exp_s}) begin
      miscompares++;
      $display("ERROR mgmt_int expected %b%b seen %b%b", exp_n, exp_s, mgmt_int_n,
               mgmt_int_serial);
    end
  endtask

  // Register write: select the index, then write the data port.
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    u_host_port_model.strobe(0, idx);
    u_host_port_model.strobe(1, val);
  endtask

  // Register read: the note is queued before the strobe is issued.
  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
    u_host_port_model.strobe(0, idx);
    exp_q.push_back(exp);
    u_host_port_model.strobe(2, 8'h00);
  endtask

  // One kind of wake cause per round, each seen by one rising edge.
  task automatic wake(input int c);
    @(negedge sys_clk);
    case (c)
      0: dev_access = 4'hF;
      1: dev_irq = 4'hF;
      2: begin
        prt_dack = 1'b1;
        fdc_dack = 1'b1;
        uart_a.rx_start = 1'b1;
        uart_b.tx_start = 1'b1;
      end
      default: begin
        prt_status = ~prt_status;
        fdc_motor = 4'h1;
        uart_a.modem = ~uart_a.modem;
        uart_b.modem = ~uart_b.modem;
      end
    endcase
    @(negedge sys_clk);
    dev_access = 4'h0;
    dev_irq = 4'h0;
    prt_dack = 1'b0;
    fdc_dack = 1'b0;
    uart_a.rx_start = 1'b0;
    uart_b.tx_start = 1'b0;
    // Motor bits drop again so the floppy may sleep in the next round.
    fdc_motor = 4'h0;
  endtask

  // Ends the run with the counts and the verdict.
  task automatic print_verdict();
    $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, read monitor and watchdog
  // ----------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;

  // A read strobe taken at a rising edge yields data checked at the next falling edge.
  always @(posedge sys_clk) begin
    rd_pend <= host.data_rd & host.ext_mode;
  end

  always @(negedge sys_clk) begin
    if (rd_pend === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("ERROR read_note expected 1 seen 0");
      end else begin
        cmp_byte(exp_q.pop_front(), host_rdata);
      end
    end
  end

  // A hang is cut short well inside the cycle budget.
  initial begin
    #(200000);
    miscompares++;
    $display("ERROR run_time expected end seen limit");
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'd41;
    rst_n = 1'b0;
    {dev_access, dev_irq, prt_dack, fdc_dack, fdc_motor} = '0;
    prt_status = 5'h00;
    uart_a = '0;
    uart_b = '0;
    uart_a.rx_wait_start = 1'b1;
    uart_a.tx_empty = 1'b1;
    uart_b.rx_wait_start = 1'b1;
    uart_b.tx_empty = 1'b1;
    idle_count = '0;
    {chip_power_mgmt_enable, mgmt_int_pin_enable, serial_irq_mode, tmin_sel} = '0;
    dev_pm_enable = 4'h0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    cmp_pins(1'b1, 1'b0);
    // Reset values of 40h to 45h and of one unmapped index.
    for (int k = 0; k < 7; k++) begin
      reg_rd(8'h40 + 8'(k), 8'h00);
    end
    // Every enable code against random levels and random gating enables.
    for (int i = 0; i < 16; i++) begin
      r = xs();
      dev_irq = r[11:8];
      mgmt_int_pin_enable = r[12] | r[13];
      chip_power_mgmt_enable = r[14] | r[15];
      serial_irq_mode = r[16];
      reg_wr(`PM_IDX_ENABLE, {r[7:4], 4'(i)});
      // The index still selects the enable register, so read it back at once.
      exp_q.push_back({4'h0, 4'(i)});
      u_host_port_model.strobe(2, 8'h00);
      reg_rd(`PM_IDX_LEVEL, {4'h0, r[11:8]});
      hit = |(4'(i) & r[11:8]) & mgmt_int_pin_enable & chip_power_mgmt_enable;
      cmp_pins(~hit, hit & serial_irq_mode);
    end
    // Writes to read-only and reserved places, and a write outside the mode, change nothing.
    reg_wr(`PM_IDX_LEVEL, 8'hFF);
    reg_wr(`PM_IDX_RSVD_A, 8'hFF);
    reg_wr(`PM_IDX_RSVD_B, 8'hFF);
    u_host_port_model.set_ext(1'b0);
    reg_wr(`PM_IDX_ENABLE, 8'h00);
    u_host_port_model.set_ext(1'b1);
    reg_rd(`PM_IDX_RSVD_B, 8'h00);
    reg_rd(`PM_IDX_ENABLE, 8'h0F);
    reg_rd(`PM_IDX_RSVD_A, 8'h00);
    reg_rd(`PM_IDX_LEVEL, {4'h0, dev_irq});
    // Power-down: counts of 9 to 12 one-second ticks, all devices quiet.
    @(negedge sys_clk);
    dev_irq = 4'h0;
    chip_power_mgmt_enable = 1'b1;
    dev_pm_enable = 4'hF;
    for (int k = 0; k < 4; k++) begin
      r = xs();
      idle_count[k] = 8'h09 + {6'h00, r[1:0]};
    end
    for (int c = 0; c < 4; c++) begin
      repeat (70) @(negedge sys_clk);
      reg_rd(`PM_IDX_IDLE, 8'h0F);
      reg_rd(`PM_IDX_WAKE, 8'h00);
      wake(c);
      reg_rd(`PM_IDX_WAKE, 8'h0F);
      reg_rd(`PM_IDX_IDLE, 8'h00);
    end
    // Write-one-to-clear while the devices are still working.
    reg_wr(`PM_IDX_WAKE, 8'hF5);
    reg_rd(`PM_IDX_WAKE, 8'h0A);
    reg_wr(`PM_IDX_WAKE, 8'h00);
    reg_rd(`PM_IDX_WAKE, 8'h0A);
    // A zero count keeps the second UART in its working state.
    idle_count[0] = 8'h00;
    repeat (70) @(negedge sys_clk);
    reg_rd(`PM_IDX_IDLE, 8'h0E);
    reg_rd(`PM_IDX_WAKE, 8'h00);
    reg_wr(`PM_IDX_IDLE, 8'h06);
    reg_rd(`PM_IDX_IDLE, 8'h08);
    // Minute ticks: a count of two cannot expire within 240 cycles.
    tmin_sel = 1'b1;
    idle_count[1] = 8'h02;
    dev_access = 4'h2;
    @(negedge sys_clk);
    dev_access = 4'h0;
    repeat (200) @(negedge sys_clk);
    reg_rd(`PM_IDX_IDLE, 8'h08);
    reg_rd(`PM_IDX_WAKE, 8'h02);
    repeat (300) @(negedge sys_clk);
    reg_rd(`PM_IDX_IDLE, 8'h0A);
    reg_rd(`PM_IDX_WAKE, 8'h00);
    // A reset in mid-run returns the flags and the enables to zero.
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    cmp_pins(1'b1, 1'b0);
    reg_rd(`PM_IDX_IDLE, 8'h00);
    reg_rd(`PM_IDX_ENABLE, 8'h00);
    repeat (4) @(negedge sys_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
